// ==== src/cie_regs.svh ====
`ifndef CIE_REGS_SVH
`define CIE_REGS_SVH

// ----------------------------------------------------------------
// register addresses (9-bit data memory map)
// ----------------------------------------------------------------
`define CIE_ADDR_W 9
`define CIE_INTCTL_BANK0 9'h00B
`define CIE_INTCTL_BANK1 9'h08B
`define CIE_INTCTL_BANK2 9'h10B
`define CIE_INTCTL_BANK3 9'h18B
`define CIE_PIE_ADDR 9'h08C

// ----------------------------------------------------------------
// interrupt control bit positions
// ----------------------------------------------------------------
`define CIE_GIE_BIT 7
`define CIE_PERIPH_IRQ_ENABLE_BIT 6
`define CIE_TMR_ZERO_OVF_ENABLE_BIT 5
`define CIE_EXTIE_BIT 4
`define CIE_PCIE_BIT 3
`define CIE_TMR_ZERO_OVF_FLAG_BIT 2
`define CIE_EXTIF_BIT 1
`define CIE_PCIF_BIT 0

// ----------------------------------------------------------------
// peripheral enable bit positions and masks
// ----------------------------------------------------------------
`define CIE_ADC_IRQ_ENABLE_BIT 6
`define CIE_SSIE_BIT 3
`define CIE_CCIE_BIT 2
`define CIE_T2IE_BIT 1
`define CIE_T1IE_BIT 0
`define CIE_PIE_IMPL_MASK 8'h4F
`define CIE_PIE_RESET 8'h00
`define CIE_INTCTL_RESET 8'h00

`endif

// ==== src/cie_pkg.sv ====
package cie_pkg;

    typedef logic [7:0] cie_byte_t;

    // register bus from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } cie_bus_s;

    // peripheral flags, already latched by each peripheral
    typedef struct packed {
        logic adc;
        logic sync_serial;
        logic capcomp;
        logic tmr_two;
        logic tmr_one;
    } cie_periph_s;

    // core source events from the edge/change detector
    typedef struct packed {
        logic ext_edge;
        logic port_change;
    } cie_evt_s;

endpackage

// ==== src/cie_pin_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "cie_regs.svh"

module cie_pin_detect (
    // clock and reset
    input wire logic clk,
    input wire logic rst_sync_n,
    // pins
    input wire logic ext_irq_pin,
    input wire logic [3:0] upper_port_pins,
    input wire logic ext_edge_select,
    // events
    output var cie_pkg::cie_evt_s evt
);

    typedef struct packed {
        logic ext_prev;
        logic [3:0] port_prev;
        logic primed;
    } cie_det_s;

    cie_det_s st_q;
    cie_det_s st_d;

    // ----------------------------------------------------------------
    // edge and change detection
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.ext_prev = ext_irq_pin;
        st_d.port_prev = upper_port_pins;
        st_d.primed = 1'b1;
        if (ext_edge_select)
        begin
            evt.ext_edge = st_q.primed & ext_irq_pin & ~st_q.ext_prev;
        end
        else
        begin
            evt.ext_edge = st_q.primed & ~ext_irq_pin & st_q.ext_prev;
        end
        // no event on first cycle: previous pin state is unknown then
        evt.port_change = st_q.primed & (|(upper_port_pins ^ st_q.port_prev));
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule // cie_pin_detect

`default_nettype wire

// ==== src/cie_core.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "cie_regs.svh"

module cie_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access from the core
    input wire cie_pkg::cie_bus_s bus,
    output logic [7:0] rdata,
    // interrupt sources
    input wire logic tmr_zero_ovf,
    input wire logic ext_irq_pin,
    input wire logic [3:0] upper_port_pins,
    input wire logic ext_edge_select,
    input wire cie_pkg::cie_periph_s periph_flags,
    // request to the core
    output logic irq_req
);

    typedef struct packed {
        logic [7:0] intctl;
        logic [7:0] pie;
        logic [7:0] rdata;
        logic irq;
    } cie_state_s;

    cie_state_s st_q;
    cie_state_s st_d;
    logic [1:0] rst_sync_q;
    logic rst_sync_n;
    cie_pkg::cie_evt_s evt;

    assign rst_sync_n = rst_sync_q[1];
    assign rdata = st_q.rdata;
    assign irq_req = st_q.irq;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    cie_pin_detect u_detect (
        .clk(clk),
        .rst_sync_n(rst_sync_n),
        .ext_irq_pin(ext_irq_pin),
        .upper_port_pins(upper_port_pins),
        .ext_edge_select(ext_edge_select),
        .evt(evt)
    );

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // all four banks alias
    function automatic logic hit_intctl(input logic [8:0] a);
        hit_intctl = (a == `CIE_INTCTL_BANK0) || (a == `CIE_INTCTL_BANK1) ||
                     (a == `CIE_INTCTL_BANK2) || (a == `CIE_INTCTL_BANK3);
    endfunction

    // flag update: hardware set beats software clear
    function automatic logic flag_next(input logic cur, input logic wr,
                                       input logic wval, input logic set);
        flag_next = set | (wr ? wval : cur);
    endfunction

    // ----------------------------------------------------------------
    // register and request logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic wr_ic;
        logic wr_pie;
        logic core_hit;
        logic per_hit;
        logic [7:0] ic;
        wr_ic = bus.wr && hit_intctl(bus.addr);
        wr_pie = bus.wr && (bus.addr == `CIE_PIE_ADDR);
        ic = st_q.intctl;
        core_hit = 1'b0;
        per_hit = 1'b0;
        st_d = st_q;
        // enables are plain storage
        if (wr_ic)
        begin
            st_d.intctl[7:3] = bus.wdata[7:3];
        end
        st_d.intctl[`CIE_TMR_ZERO_OVF_FLAG_BIT] = flag_next(st_q.intctl[`CIE_TMR_ZERO_OVF_FLAG_BIT], wr_ic,
                                               bus.wdata[`CIE_TMR_ZERO_OVF_FLAG_BIT], tmr_zero_ovf);
        st_d.intctl[`CIE_EXTIF_BIT] = flag_next(st_q.intctl[`CIE_EXTIF_BIT], wr_ic,
                                                bus.wdata[`CIE_EXTIF_BIT], evt.ext_edge);
        st_d.intctl[`CIE_PCIF_BIT] = flag_next(st_q.intctl[`CIE_PCIF_BIT], wr_ic,
                                               bus.wdata[`CIE_PCIF_BIT], evt.port_change);
        if (wr_pie)
        begin
            st_d.pie = bus.wdata & `CIE_PIE_IMPL_MASK;
        end
        // read data, registered; unmapped addresses read zero
        if (hit_intctl(bus.addr))
        begin
            st_d.rdata = st_q.intctl;
        end
        else if (bus.addr == `CIE_PIE_ADDR)
        begin
            st_d.rdata = st_q.pie;
        end
        else
        begin
            st_d.rdata = 8'h00;
        end
        core_hit = (ic[`CIE_TMR_ZERO_OVF_ENABLE_BIT] & ic[`CIE_TMR_ZERO_OVF_FLAG_BIT]) |
                   (ic[`CIE_EXTIE_BIT] & ic[`CIE_EXTIF_BIT]) |
                   (ic[`CIE_PCIE_BIT] & ic[`CIE_PCIF_BIT]);
        per_hit = (st_q.pie[`CIE_ADC_IRQ_ENABLE_BIT] & periph_flags.adc) |
                  (st_q.pie[`CIE_SSIE_BIT] & periph_flags.sync_serial) |
                  (st_q.pie[`CIE_CCIE_BIT] & periph_flags.capcomp) |
                  (st_q.pie[`CIE_T2IE_BIT] & periph_flags.tmr_two) |
                  (st_q.pie[`CIE_T1IE_BIT] & periph_flags.tmr_one);
        // combine with global and peripheral gates
        st_d.irq = ic[`CIE_GIE_BIT] & (core_hit | (ic[`CIE_PERIPH_IRQ_ENABLE_BIT] & per_hit));
    end

    // reset values; bit 0 reset to 0 as a safe pick
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st_q.intctl <= `CIE_INTCTL_RESET;
            st_q.pie <= `CIE_PIE_RESET;
            st_q.rdata <= 8'h00;
            st_q.irq <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    // ----------------------------------------------------------------
    // request checks
    // ----------------------------------------------------------------
    AST_GIE_BLOCKS: assert property (!st_q.intctl[7] |=> !irq_req)
        else $error("request while global enable clear");
    AST_PERIPH_IRQ_ENABLE_BLOCKS: assert property (
        (!st_q.intctl[6] && !(|(st_q.intctl[5:3] & st_q.intctl[2:0]))) |=> !irq_req)
        else $error("peripheral request passed with peripheral enable clear");
    AST_T0_REQ: assert property (
        (st_q.intctl[7] && st_q.intctl[5] && st_q.intctl[2]) |=> irq_req)
        else $error("timer zero request missing");
    AST_EXT_REQ: assert property (
        (st_q.intctl[7] && st_q.intctl[4] && st_q.intctl[1]) |=> irq_req)
        else $error("external request missing");
    AST_PC_REQ: assert property (
        (st_q.intctl[7] && st_q.intctl[3] && st_q.intctl[0]) |=> irq_req)
        else $error("port change request missing");
    AST_CORE_MASKED: assert property (
        (st_q.intctl[6:3] == 4'h0) |=> !irq_req)
        else $error("request with every source enable clear");
    AST_PIE_REQ: assert property (
        (st_q.intctl[7] && st_q.intctl[6] && st_q.pie[0] && periph_flags.tmr_one)
        |=> irq_req)
        else $error("peripheral request missing");
    AST_ADC_REQ: assert property (
        (st_q.intctl[7] && st_q.intctl[6] && st_q.pie[6] && periph_flags.adc)
        |=> irq_req)
        else $error("adc request missing");
    AST_SS_REQ: assert property (
        (st_q.intctl[7] && st_q.intctl[6] && st_q.pie[3] && periph_flags.sync_serial)
        |=> irq_req)
        else $error("serial request missing");
    AST_CC_REQ: assert property (
        (st_q.intctl[7] && st_q.intctl[6] && st_q.pie[2] && periph_flags.capcomp)
        |=> irq_req)
        else $error("capture compare request missing");
    AST_T2_REQ: assert property (
        (st_q.intctl[7] && st_q.intctl[6] && st_q.pie[1] && periph_flags.tmr_two)
        |=> irq_req)
        else $error("timer two request missing");
    AST_PIE_MASKED: assert property (
        (st_q.intctl[5:3] == 3'h0 && st_q.pie == 8'h00) |=> !irq_req)
        else $error("request with every enable clear");

    // ----------------------------------------------------------------
    // flag checks
    // ----------------------------------------------------------------
    AST_T0_SET: assert property (tmr_zero_ovf |=> st_q.intctl[2])
        else $error("timer zero flag not set");
    AST_EXT_SET: assert property (evt.ext_edge |=> st_q.intctl[1])
        else $error("external flag not set");
    AST_PC_SET: assert property (evt.port_change |=> st_q.intctl[0])
        else $error("port change flag not set");
    AST_FLAG_HOLD: assert property (
        (st_q.intctl[2] && !(bus.wr && hit_intctl(bus.addr))) |=> st_q.intctl[2])
        else $error("timer zero flag dropped without write");
    AST_EXT_HOLD: assert property (
        (st_q.intctl[1] && !(bus.wr && hit_intctl(bus.addr))) |=> st_q.intctl[1])
        else $error("external flag dropped without write");
    AST_PC_HOLD: assert property (
        (st_q.intctl[0] && !(bus.wr && hit_intctl(bus.addr))) |=> st_q.intctl[0])
        else $error("port change flag dropped without write");
    AST_T0_CLEAR: assert property (
        (bus.wr && hit_intctl(bus.addr) && !bus.wdata[2] && !tmr_zero_ovf)
        |=> !st_q.intctl[2])
        else $error("timer zero flag not cleared by write");
    AST_EXT_CLEAR: assert property (
        (bus.wr && hit_intctl(bus.addr) && !bus.wdata[1] && !evt.ext_edge)
        |=> !st_q.intctl[1])
        else $error("external flag not cleared by write");
    AST_PC_CLEAR: assert property (
        (bus.wr && hit_intctl(bus.addr) && !bus.wdata[0] && !evt.port_change)
        |=> !st_q.intctl[0])
        else $error("port change flag not cleared by write");
    AST_EDGE_LEVEL: assert property (
        evt.ext_edge |-> (ext_irq_pin == ext_edge_select))
        else $error("external edge of wrong polarity");

    // ----------------------------------------------------------------
    // register checks
    // ----------------------------------------------------------------
    AST_PIE_ZERO: assert property (st_q.pie[7] == 1'b0 && st_q.pie[5:4] == 2'b00)
        else $error("unimplemented peripheral bits set");
    AST_PIE_WR: assert property (
        (bus.wr && bus.addr == `CIE_PIE_ADDR) |=> st_q.pie == ($past(bus.wdata) & 8'h4F))
        else $error("peripheral enable write wrong");
    AST_PIE_HOLD: assert property (
        !(bus.wr && bus.addr == `CIE_PIE_ADDR) |=> $stable(st_q.pie))
        else $error("peripheral enables changed without write");
    AST_EN_HOLD: assert property (
        !(bus.wr && hit_intctl(bus.addr)) |=> $stable(st_q.intctl[7:3]))
        else $error("enable bits changed without write");
    AST_ALIAS_B0: assert property (
        (bus.wr && bus.addr == `CIE_INTCTL_BANK0)
        |=> st_q.intctl[7:3] == $past(bus.wdata[7:3]))
        else $error("bank zero write lost");
    AST_ALIAS_B1: assert property (
        (bus.wr && bus.addr == `CIE_INTCTL_BANK1)
        |=> st_q.intctl[7:3] == $past(bus.wdata[7:3]))
        else $error("bank one write lost");
    AST_ALIAS_B2: assert property (
        (bus.wr && bus.addr == `CIE_INTCTL_BANK2)
        |=> st_q.intctl[7:3] == $past(bus.wdata[7:3]))
        else $error("bank two write lost");
    AST_ALIAS: assert property (
        (bus.wr && bus.addr == `CIE_INTCTL_BANK3)
        |=> st_q.intctl[7:3] == $past(bus.wdata[7:3]))
        else $error("bank alias write lost");
    AST_RD_CTL: assert property (
        hit_intctl(bus.addr) |=> rdata == $past(st_q.intctl))
        else $error("control read data wrong");
    AST_RD_PIE: assert property (
        (bus.addr == `CIE_PIE_ADDR) |=> rdata == $past(st_q.pie))
        else $error("peripheral enable read data wrong");
    AST_RD_NONE: assert property (
        (!hit_intctl(bus.addr) && bus.addr != `CIE_PIE_ADDR)
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // ----------------------------------------------------------------
    // scenario covers
    // ----------------------------------------------------------------
    COV_T0_IRQ: cover property (tmr_zero_ovf ##1 st_q.intctl[2] ##1 irq_req);
    COV_CLEAR_RACE: cover property (bus.wr && hit_intctl(bus.addr) && !bus.wdata[2]
                                    && tmr_zero_ovf);
    COV_PERIPH_IRQ: cover property (st_q.intctl[6] && per_hit_c() ##1 irq_req);
    COV_EXT: cover property (evt.ext_edge ##2 irq_req);
    COV_READ: cover property (bus.rd && hit_intctl(bus.addr) ##1 rdata != 8'h00);

    function automatic logic per_hit_c();
        per_hit_c = |(st_q.pie & {1'b0, periph_flags.adc, 2'b00, periph_flags.sync_serial,
                                  periph_flags.capcomp, periph_flags.tmr_two,
                                  periph_flags.tmr_one});
    endfunction

endmodule // cie_core

`default_nettype wire

// ==== tb/cie_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// interrupt source model
// ------------------------------------------------
module cie_src_model (
    // clock
    input wire logic clk,
    // source outputs
    output logic tmr_zero_ovf,
    output logic ext_irq_pin,
    output logic [3:0] upper_port_pins,
    output logic ext_edge_select,
    output var cie_pkg::cie_periph_s periph_flags
);
    initial
    begin
        tmr_zero_ovf = 1'h0;
        ext_irq_pin = 1'h0;
        upper_port_pins = 4'h0;
        ext_edge_select = 1'h1;
        periph_flags = '0;
    end

    task automatic ovf_pulse();
    begin
        @(posedge clk) tmr_zero_ovf <= 1'h1;
        @(posedge clk) tmr_zero_ovf <= 1'h0;
    end
    endtask

    // levels held; three idle edges let the detector settle
    task automatic set_pins(input logic sel, input logic pin, input logic [3:0] up);
    begin
        @(posedge clk);
        ext_edge_select <= sel;
        ext_irq_pin <= pin;
        upper_port_pins <= up;
        repeat (3) @(posedge clk);
    end
    endtask

    // peripherals latch their own flags, so a level is honest here
    task automatic set_periph(input cie_pkg::cie_periph_s f);
    begin
        @(posedge clk) periph_flags <= f;
    end
    endtask
endmodule // cie_src_model

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk;
    logic rst_n;
    cie_pkg::cie_bus_s bus;
    logic [7:0] rdata;
    logic irq_req;
    logic ovf;
    logic pin;
    logic [3:0] up;
    logic sel;
    cie_pkg::cie_periph_s pf;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [8:0] banks [4] = '{9'h00B, 9'h08B, 9'h10B, 9'h18B};
    // enable bit of each peripheral flag, flag bit 0 first
    logic [7:0] pie_bit [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40};

    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    cie_src_model src_u (.clk(clk), .tmr_zero_ovf(ovf), .ext_irq_pin(pin),
        .upper_port_pins(up), .ext_edge_select(sel), .periph_flags(pf));
    cie_core dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .tmr_zero_ovf(ovf), .ext_irq_pin(pin), .upper_port_pins(up),
        .ext_edge_select(sel), .periph_flags(pf), .irq_req(irq_req));

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic end_sim();
    begin
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
    begin
        @(posedge clk) bus <= '{1'h1, 1'h0, a, d};
        @(posedge clk) bus.wr <= 1'h0;
    end
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] m, input logic [7:0] exp);
    begin
        @(posedge clk) bus <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge clk);
        #1 chk(rdata & m, exp);
    end
    endtask

    task automatic irq(input logic e);
    begin
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq_req}, {7'h00, e});
    end
    endtask

    // hang guard, far above the under two hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            end_sim();
        end
    end

    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial
    begin
        rst_n = 1'h0;
        bus = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rd(9'h00B, 8'hFE, 8'h00);
        rd(9'h08C, 8'hFF, 8'h00);
        rd(9'h0F0, 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(banks[i], 8'h08 << i);
            rd(banks[(i + 1) % 4], 8'hFF, 8'h08 << i);
        end
        wr(9'h08C, 8'hFF);
        rd(9'h08C, 8'hFF, 8'h4F);
        wr(9'h00B, 8'h00);
        src_u.ovf_pulse();
        irq(1'h0);
        rd(9'h00B, 8'hFF, 8'h04);
        wr(9'h00B, 8'h00);
        rd(9'h00B, 8'hFF, 8'h00);
        wr(9'h00B, 8'hA0);
        src_u.ovf_pulse();
        irq(1'h1);
        wr(9'h00B, 8'h24);
        irq(1'h0);
        fork
            wr(9'h00B, 8'h00);
            src_u.ovf_pulse();
        join
        rd(9'h00B, 8'hFF, 8'h04);
        wr(9'h00B, 8'h00);
        src_u.set_pins(1'h1, 1'h1, 4'h0);
        rd(9'h00B, 8'hFF, 8'h02);
        wr(9'h00B, 8'h00);
        src_u.set_pins(1'h1, 1'h0, 4'h0);
        rd(9'h00B, 8'hFF, 8'h00);
        src_u.set_pins(1'h0, 1'h0, 4'h0);
        src_u.set_pins(1'h0, 1'h1, 4'h0);
        rd(9'h00B, 8'hFF, 8'h00);
        wr(9'h00B, 8'h90);
        src_u.set_pins(1'h0, 1'h0, 4'h0);
        rd(9'h00B, 8'hFF, 8'h92);
        wr(9'h00B, 8'h92);
        irq(1'h1);
        wr(9'h00B, 8'h80);
        irq(1'h0);
        src_u.set_pins(1'h0, 1'h0, 4'h8);
        rd(9'h00B, 8'hFF, 8'h81);
        wr(9'h00B, 8'h89);
        irq(1'h1);
        wr(9'h00B, 8'h88);
        rd(9'h00B, 8'hFF, 8'h88);
        src_u.set_periph(5'h10);
        wr(9'h00B, 8'h80);
        irq(1'h0);
        wr(9'h00B, 8'hC0);
        irq(1'h1);
        wr(9'h08C, 8'h00);
        irq(1'h0);
        for (int i = 0; i < 5; i++)
        begin
            src_u.set_periph(5'h01 << i);
            wr(9'h08C, pie_bit[i]);
            irq(1'h1);
            wr(9'h08C, 8'h4F & ~pie_bit[i]);
            irq(1'h0);
        end
        // second reset in mid-run
        @(posedge clk) rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rd(9'h18B, 8'hFE, 8'h00);
        rd(9'h08C, 8'hFF, 8'h00);
        irq(1'h0);
        end_sim();
    end
endmodule // tb_top

`default_nettype wire
